/* pkg/hprw_map.svh */
// Offsets, field positions, reset values and timing counts of the host power sequencer
// Functional notes
// - Reset and power pins float when idle, driven only for a pulse.
// - Reset-invert mask bit makes the reset pulse drive high, not low.
// - Power-invert mask bit makes the power pulse drive high, not low.
// - Auto-polarity bit: active level is opposite of the line's idle level.
// - Confirm held 4 s with host up and enabled: reset pulse 1 s.
// - After keypad reset, commands are ignored until the self restart.
// - Confirm held 0.25 s with host down: power pulse, then restart.
// - Cancel held 4 s with host up: power pulse, up to 5 s more.
// - Blank mode and host down: display and backlight off, keys watched.
// - Blank mode: host coming back up restarts the block like power-up.
// - Pulse length counts 1/32 s units; 255 holds until power drops.
// - Power config carries mask, optional length; missing length means default.
// - Watchdog timeout zero disables the watchdog, also a running one.
// - Nonzero timeout must be refreshed in time, else host is reset.
// - Watchdog off at power-up and after it fires once.
// - Status report carries the function mask and the watchdog count.
// - Function mask and pulse length are kept by the boot-state store.
`ifndef HPRW_MAP_SVH
`define HPRW_MAP_SVH

`define HPRW_OFS_FUNC 5'h00
`define HPRW_OFS_WDOG 5'h04
`define HPRW_OFS_STATUS 5'h08
`define HPRW_OFS_BOOT 5'h0C
`define HPRW_OFS_REPORT 5'h10

`define HPRW_BIT_AUTO 0
`define HPRW_BIT_RINV 1
`define HPRW_BIT_PINV 2
`define HPRW_BIT_BLANK 4
`define HPRW_BIT_KRST 5
`define HPRW_BIT_KON 6
`define HPRW_BIT_KOFF 7

`define HPRW_MASK_RST 8'h00
`define HPRW_LEN_DEFAULT 8'h20
`define HPRW_LEN_FOREVER 8'hFF

`define HPRW_CLK_NS 10
`define HPRW_TICK_NS 31250000
`define HPRW_TICK_CYCLES (`HPRW_TICK_NS / `HPRW_CLK_NS)
`define HPRW_TICKS_PER_S 32
`define HPRW_KEY_LONG_MS 4000
`define HPRW_KEY_SHORT_MS 250
`define HPRW_RST_PULSE_MS 1000
`define HPRW_EXT_MS 5000
`define HPRW_KEY_LONG_TICKS (`HPRW_KEY_LONG_MS * `HPRW_TICKS_PER_S / 1000)
`define HPRW_KEY_SHORT_TICKS (`HPRW_KEY_SHORT_MS * `HPRW_TICKS_PER_S / 1000)
`define HPRW_RST_TICKS (`HPRW_RST_PULSE_MS * `HPRW_TICKS_PER_S / 1000)
`define HPRW_EXT_TICKS (`HPRW_EXT_MS * `HPRW_TICKS_PER_S / 1000)

`endif

/* pkg/hprw_pkg.sv */
// Types of the host power sequencer
package hprw_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RST,
    ST_PWR,
    ST_EXT,
    ST_RESTART
  } hprw_state_type;
endpackage : hprw_pkg

/* hdl/hprw_pin_drv.sv */
// Registered tri-state pulse driver for one host control line
module hprw_pin_drv (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic drive_hi,
  output logic pin_o,
  output logic pin_oe
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o <= active & drive_hi;
      pin_oe <= active;
    end
  end
endmodule : hprw_pin_drv

/* hdl/hprw_top.sv */
// Host power, reset and watchdog sequencer with Avalon-MM registers
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`include "hprw_map.svh"
module hprw_top #(
  parameter int unsigned TICK_CYCLES = `HPRW_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sense_i,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  input wire logic pwr_pin_i,
  output logic pwr_pin_o,
  output logic pwr_pin_oe,
  input wire logic key_confirm_i,
  input wire logic key_cancel_i,
  output logic display_blank,
  output logic backlight_off
);
  logic rst_meta_n;
  logic rst_n;
  logic [4:0] pin_raw;
  logic [4:0] pin_meta;
  logic [4:0] pin_s;
  logic sense;
  logic sense_prev;
  logic key_ok;
  logic key_no;
  logic [31:0] tick_div;
  logic tick;
  logic [7:0] confirm_cnt;
  logic [7:0] cancel_cnt;
  logic confirm_long;
  logic confirm_short;
  logic cancel_long;
  logic [7:0] func_mask;
  logic [7:0] pulse_len;
  logic [7:0] boot_mask;
  logic [7:0] boot_len;
  logic req;
  logic wr_ok;
  logic [31:0] rd_mux;
  logic [7:0] wd_cnt;
  logic [4:0] wd_sub;
  logic wd_en;
  logic wd_write;
  logic wd_expire;
  logic wd_pending;
  logic wd_take;
  hprw_pkg::hprw_state_type state;
  logic [7:0] time_cnt;
  logic pwr_forever;
  logic off_mode;
  logic restart_after;
  logic lock_cmds;
  logic rst_pol;
  logic pwr_pol;
  logic rst_idle_lvl;
  logic pwr_idle_lvl;
  logic [1:0] quiet_cnt;
  logic blank_restart;
  logic key_rst_go;
  logic key_on_go;
  logic key_off_go;
  logic pol_rst_now;
  logic pol_pwr_now;
  logic start_rst;
  logic start_pwr;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // Pins are asynchronous; only pin_s is read by logic
  assign pin_raw = {key_cancel_i, key_confirm_i, pwr_pin_i, rst_pin_i, sense_i};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 5'h00;
      pin_s <= 5'h00;
    end else begin
      pin_meta <= pin_raw;
      pin_s <= pin_meta;
    end
  end
  assign sense = pin_s[0];
  assign key_ok = pin_s[3];
  assign key_no = pin_s[4];

  // 1/32 s time base shared by keys, pulses and watchdog
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_div <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (tick_div == 32'(TICK_CYCLES - 1)) begin
      tick_div <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      tick_div <= tick_div + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // Hold counters clear on release, so a short press never fires a long action
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      confirm_cnt <= 8'h00;
      cancel_cnt <= 8'h00;
    end else begin
      if (!key_ok) begin
        confirm_cnt <= 8'h00;
      end else if (tick && confirm_cnt != 8'hFF) begin
        confirm_cnt <= confirm_cnt + 8'h01;
      end
      if (!key_no) begin
        cancel_cnt <= 8'h00;
      end else if (tick && cancel_cnt != 8'hFF) begin
        cancel_cnt <= cancel_cnt + 8'h01;
      end
    end
  end
  assign confirm_long = key_ok && tick && confirm_cnt == 8'(`HPRW_KEY_LONG_TICKS - 1);
  assign confirm_short = key_ok && tick && confirm_cnt == 8'(`HPRW_KEY_SHORT_TICKS - 1);
  assign cancel_long = key_no && tick && cancel_cnt == 8'(`HPRW_KEY_LONG_TICKS - 1);

  assign key_rst_go = func_mask[`HPRW_BIT_KRST] && sense && confirm_long;
  assign key_on_go = func_mask[`HPRW_BIT_KON] && !sense && confirm_short;
  assign key_off_go = func_mask[`HPRW_BIT_KOFF] && sense && cancel_long;
  assign blank_restart = func_mask[`HPRW_BIT_BLANK] && sense && !sense_prev;
  assign wd_take = state == hprw_pkg::ST_IDLE && !blank_restart && wd_pending;
  assign start_rst = state == hprw_pkg::ST_IDLE && !blank_restart && (wd_pending || key_rst_go);
  assign start_pwr = state == hprw_pkg::ST_IDLE && !blank_restart && !wd_pending && !key_rst_go
                     && (key_on_go || key_off_go);

  // Idle levels are sampled only after the line has been released a few cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_cnt <= 2'h0;
      rst_idle_lvl <= 1'b1;
      pwr_idle_lvl <= 1'b1;
    end else if (rst_pin_oe || pwr_pin_oe) begin
      quiet_cnt <= 2'h0;
    end else if (quiet_cnt != 2'h3) begin
      quiet_cnt <= quiet_cnt + 2'h1;
    end else begin
      rst_idle_lvl <= pin_s[1];
      pwr_idle_lvl <= pin_s[2];
    end
  end
  assign pol_rst_now = func_mask[`HPRW_BIT_AUTO] ? !rst_idle_lvl : func_mask[`HPRW_BIT_RINV];
  assign pol_pwr_now = func_mask[`HPRW_BIT_AUTO] ? !pwr_idle_lvl : func_mask[`HPRW_BIT_PINV];

  // Sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= hprw_pkg::ST_IDLE;
      time_cnt <= 8'h00;
      pwr_forever <= 1'b0;
      off_mode <= 1'b0;
      restart_after <= 1'b0;
      lock_cmds <= 1'b0;
      rst_pol <= 1'b0;
      pwr_pol <= 1'b0;
      sense_prev <= 1'b0;
    end else begin
      sense_prev <= sense;
      case (state)
        hprw_pkg::ST_IDLE: begin
          if (blank_restart) begin
            state <= hprw_pkg::ST_RESTART;
          end else if (start_rst) begin
            state <= hprw_pkg::ST_RST;
            time_cnt <= 8'(`HPRW_RST_TICKS);
            restart_after <= !wd_pending;
            lock_cmds <= !wd_pending;
            rst_pol <= pol_rst_now;
          end else if (start_pwr) begin
            state <= hprw_pkg::ST_PWR;
            time_cnt <= pulse_len;
            pwr_forever <= pulse_len == `HPRW_LEN_FOREVER;
            off_mode <= key_off_go;
            restart_after <= key_on_go;
            pwr_pol <= pol_pwr_now;
          end
        end
        hprw_pkg::ST_RST: begin
          if (tick) begin
            time_cnt <= time_cnt - 8'h01;
            if (time_cnt <= 8'h01) begin
              state <= restart_after ? hprw_pkg::ST_RESTART : hprw_pkg::ST_IDLE;
            end
          end
        end
        hprw_pkg::ST_PWR: begin
          // A held line is only ended by the supply going away
          if (tick && !pwr_forever) begin
            time_cnt <= time_cnt - 8'h01;
            if (time_cnt <= 8'h01) begin
              if (off_mode && key_no) begin
                state <= hprw_pkg::ST_EXT;
                time_cnt <= 8'(`HPRW_EXT_TICKS);
              end else begin
                state <= restart_after ? hprw_pkg::ST_RESTART : hprw_pkg::ST_IDLE;
              end
            end
          end
        end
        hprw_pkg::ST_EXT: begin
          if (!key_no) begin
            state <= hprw_pkg::ST_IDLE;
          end else if (tick) begin
            time_cnt <= time_cnt - 8'h01;
            if (time_cnt <= 8'h01) begin
              state <= hprw_pkg::ST_IDLE;
            end
          end
        end
        hprw_pkg::ST_RESTART: begin
          state <= hprw_pkg::ST_IDLE;
          lock_cmds <= 1'b0;
        end
        default: begin
          state <= hprw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  hprw_pin_drv u_rst_drv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .active(state == hprw_pkg::ST_RST),
    .drive_hi(rst_pol),
    .pin_o(rst_pin_o),
    .pin_oe(rst_pin_oe)
  );

  hprw_pin_drv u_pwr_drv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .active(state == hprw_pkg::ST_PWR || state == hprw_pkg::ST_EXT),
    .drive_hi(pwr_pol),
    .pin_o(pwr_pin_o),
    .pin_oe(pwr_pin_oe)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      display_blank <= 1'b0;
      backlight_off <= 1'b0;
    end else begin
      display_blank <= func_mask[`HPRW_BIT_BLANK] && !sense;
      backlight_off <= func_mask[`HPRW_BIT_BLANK] && !sense;
    end
  end

  // Bus slave: one wait cycle per transfer, answer from registers
  assign req = avs_read || avs_write;
  assign wr_ok = avs_write && !avs_waitrequest && !lock_cmds;
  assign wd_write = wr_ok && avs_address == `HPRW_OFS_WDOG && avs_byteenable[0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    case (avs_address)
      `HPRW_OFS_FUNC: rd_mux = {16'h0000, pulse_len, func_mask};
      `HPRW_OFS_WDOG: rd_mux = {24'h00_0000, wd_cnt};
      `HPRW_OFS_STATUS: rd_mux = {16'h0000, wd_cnt, 2'h0, wd_en, display_blank,
                                  pwr_pin_oe, rst_pin_oe, lock_cmds, sense};
      `HPRW_OFS_BOOT: rd_mux = {16'h0000, boot_len, boot_mask};
      `HPRW_OFS_REPORT: rd_mux = {16'h0000, wd_cnt, func_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end else begin
      avs_readdata <= 32'h0000_0000;
    end
  end

  // Boot copy lives in flops only; a full power cycle returns the reset values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      func_mask <= `HPRW_MASK_RST;
      pulse_len <= `HPRW_LEN_DEFAULT;
      boot_mask <= `HPRW_MASK_RST;
      boot_len <= `HPRW_LEN_DEFAULT;
    end else if (state == hprw_pkg::ST_RESTART) begin
      func_mask <= boot_mask;
      pulse_len <= boot_len;
    end else if (wr_ok && avs_address == `HPRW_OFS_FUNC && avs_byteenable[0]) begin
      func_mask <= avs_writedata[7:0];
      pulse_len <= avs_byteenable[1] ? avs_writedata[15:8] : `HPRW_LEN_DEFAULT;
    end else if (wr_ok && avs_address == `HPRW_OFS_BOOT) begin
      boot_mask <= func_mask;
      boot_len <= pulse_len;
    end
  end

  // Watchdog; a refresh in the expiry cycle wins and reloads
  assign wd_expire = wd_en && tick && !wd_write && wd_sub == 5'(`HPRW_TICKS_PER_S - 1)
                     && wd_cnt == 8'h01;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_en <= 1'b0;
      wd_cnt <= 8'h00;
      wd_sub <= 5'h00;
    end else if (wd_write) begin
      wd_en <= avs_writedata[7:0] != 8'h00;
      wd_cnt <= avs_writedata[7:0];
      wd_sub <= 5'h00;
    end else if (state == hprw_pkg::ST_RESTART || wd_expire) begin
      wd_en <= 1'b0;
      wd_cnt <= 8'h00;
      wd_sub <= 5'h00;
    end else if (wd_en && tick) begin
      if (wd_sub == 5'(`HPRW_TICKS_PER_S - 1)) begin
        wd_sub <= 5'h00;
        wd_cnt <= wd_cnt - 8'h01;
      end else begin
        wd_sub <= wd_sub + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_pending <= 1'b0;
    end else if (wd_expire) begin
      wd_pending <= 1'b1;
    end else if (wd_take) begin
      wd_pending <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_idle_float: assert property (state == hprw_pkg::ST_IDLE
    |=> !rst_pin_oe && !pwr_pin_oe) else $error("control line driven while idle");
  a_reset_invert: assert property (start_rst && !func_mask[`HPRW_BIT_AUTO]
    |-> ##2 rst_pin_oe && rst_pin_o == $past(func_mask[`HPRW_BIT_RINV], 2))
    else $error("reset pulse level wrong");
  a_power_invert: assert property (start_pwr && !func_mask[`HPRW_BIT_AUTO]
    |-> ##2 pwr_pin_oe && pwr_pin_o == $past(func_mask[`HPRW_BIT_PINV], 2))
    else $error("power pulse level wrong");
  a_auto_polarity: assert property (start_rst && func_mask[`HPRW_BIT_AUTO]
    |-> ##2 rst_pin_o == !$past(rst_idle_lvl, 2)) else $error("auto polarity wrong");
  a_keypad_reset: assert property (key_rst_go && start_rst
    |=> state == hprw_pkg::ST_RST ##1 rst_pin_oe) else $error("keypad reset not started");
  a_locked_writes: assert property (lock_cmds && avs_write && !avs_waitrequest
    && state != hprw_pkg::ST_RESTART |=> $stable(func_mask) && $stable(boot_mask))
    else $error("write taken while locked");
  a_power_on: assert property (start_pwr && key_on_go
    |=> state == hprw_pkg::ST_PWR && restart_after) else $error("power on not started");
  a_blank_display: assert property (func_mask[`HPRW_BIT_BLANK] && !sense
    |=> display_blank && backlight_off) else $error("display not blanked");
  a_blank_restart: assert property (state == hprw_pkg::ST_IDLE && blank_restart
    |=> state == hprw_pkg::ST_RESTART ##1 func_mask == $past(boot_mask))
    else $error("no restart on host up");
  a_hold_forever: assert property (state == hprw_pkg::ST_PWR && pwr_forever
    |=> state == hprw_pkg::ST_PWR) else $error("held pulse ended");
  a_wd_disable: assert property (wd_write && avs_writedata[7:0] == 8'h00
    && !wd_pending |=> !wd_en && !wd_pending) else $error("watchdog not disabled");
  a_wd_expiry: assert property (wd_expire && state == hprw_pkg::ST_IDLE
    && !start_pwr |=> !wd_en ##[1:3] state == hprw_pkg::ST_RST) else $error("expiry missed");

  c_keypad_reset: cover property (state == hprw_pkg::ST_RST ##1 state == hprw_pkg::ST_RESTART);
  c_power_on: cover property (state == hprw_pkg::ST_PWR && restart_after);
  c_power_ext: cover property (state == hprw_pkg::ST_EXT);
  c_wd_fire: cover property (wd_expire);
endmodule : hprw_top

/* testbench/hprw_host_model.sv */
// Host motherboard side of the power, reset and sense lines
module hprw_host_model (
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  input wire logic pwr_pin_o,
  input wire logic pwr_pin_oe,
  output logic rst_line,
  output logic pwr_line,
  output logic sense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_on = 1'b1;
  logic armed = 1'b0;
  // Control pins left as high-impedance inputs, board pull-ups idle high
  assign rst_line = rst_pin_oe ? rst_pin_o : 1'b1;
  assign pwr_line = pwr_pin_oe ? pwr_pin_o : 1'b1;
  // Power-good with pull-up and strong pull-down, default use
  assign sense = host_on;
  // Armed on a real pulse only, so the reset settling of oe flips nothing
  always @(posedge pwr_pin_oe) begin
    armed <= 1'b1;
  end
  // A finished power pulse flips the supply, like a front-panel switch
  always @(negedge pwr_pin_oe) begin
    if (armed) begin
      host_on <= !host_on;
      armed <= 1'b0;
    end
  end
endmodule : hprw_host_model

/* testbench/hprw_top_bench.sv */
// Self-checking bench of the host power, reset and watchdog sequencer
`include "hprw_map.svh"
module hprw_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short tick keeps key holds and seconds within a few thousand cycles
  localparam int T = 8;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [3:0] avs_byteenable = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sense;
  logic rst_line;
  logic pwr_line;
  logic rst_pin_o;
  logic rst_pin_oe;
  logic pwr_pin_o;
  logic pwr_pin_oe;
  logic key_confirm_i = 1'b0;
  logic key_cancel_i = 1'b0;
  logic display_blank;
  logic backlight_off;
  int error_cnt = 0;
  int cmp_count = 0;
  int pcyc = 0;
  logic plev = 1'b0;
  logic pwho = 1'b0;
  logic [11:0] pe;
  logic [31:0] rd_q[$];
  logic [11:0] pl_q[$];
  logic [15:0] lfsr_st = 16'h88D5;

  hprw_top #(.TICK_CYCLES(T)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_byteenable(avs_byteenable), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sense_i(sense), .rst_pin_i(rst_line),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .pwr_pin_i(pwr_line),
    .pwr_pin_o(pwr_pin_o), .pwr_pin_oe(pwr_pin_oe), .key_confirm_i(key_confirm_i),
    .key_cancel_i(key_cancel_i), .display_blank(display_blank),
    .backlight_off(backlight_off)
  );

  hprw_host_model host (
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .pwr_pin_o(pwr_pin_o),
    .pwr_pin_oe(pwr_pin_oe), .rst_line(rst_line), .pwr_line(pwr_line), .sense(sense)
  );

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // One transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [3:0] be,
      input logic [31:0] d, input logic [31:0] exp);
    int n;
    if (!wr) begin
      rd_q.push_back(exp);
    end
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    check("bus_answer", n < 50, 1'b1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  // Waits for a pulse on the chosen line to start and end
  task automatic wait_pulse(input bit pwr);
    int n;
    for (n = 0; n < 3000 && (pwr ? pwr_pin_oe : rst_pin_oe) !== 1'b1; n++) begin
      @(posedge sys_clk);
    end
    check("pulse_start", n < 3000, 1'b1);
    for (n = 0; n < 3000 && (pwr ? pwr_pin_oe : rst_pin_oe) !== 1'b0; n++) begin
      @(posedge sys_clk);
    end
    check("pulse_seen", n < 3000, 1'b1);
  endtask : wait_pulse

  // Presses one key for a span, or until a pulse starts
  task automatic hold(input bit cxl, input int cyc, input bit to_oe);
    int n;
    key_cancel_i <= cxl;
    key_confirm_i <= !cxl;
    for (n = 0; n < cyc; n++) begin
      @(posedge sys_clk);
      if (to_oe && (rst_pin_oe === 1'b1 || pwr_pin_oe === 1'b1)) break;
    end
    key_cancel_i <= 1'b0;
    key_confirm_i <= 1'b0;
    @(posedge sys_clk);
  endtask : hold

  // Second process: takes the oldest note when a result appears
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
      check("readdata", avs_readdata, rd_q.pop_front());
    end
    if (rst_pin_oe === 1'b1 || pwr_pin_oe === 1'b1) begin
      pcyc <= pcyc + 1;
      plev <= pwr_pin_oe ? pwr_pin_o : rst_pin_o;
      pwho <= pwr_pin_oe;
    end else if (pcyc > 0) begin
      pcyc <= 0;
      check("pulse_expected", pl_q.size() > 0, 1'b1);
      if (pl_q.size() > 0) begin
        pe = pl_q.pop_front();
        check("pulse_line", pwho, pe[11]);
        check("pulse_level", plev, pe[10]);
        check("pulse_len", pcyc >= (pe[9:0] - 1) * T && pcyc <= (pe[9:0] + 1) * T + 4,
          1'b1);
      end
    end
  end

  initial begin
    #400000;
    error_cnt++;
    $display("ERROR run_time expected done seen hang");
    stop_test();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `HPRW_OFS_FUNC, 4'hF, 32'h0, 32'h00002000);
    bus(1'b0, `HPRW_OFS_STATUS, 4'hF, 32'h0, 32'h00000001);
    bus(1'b1, 5'h14, 4'hF, {lfsr_st, lfsr_st}, 32'h0);
    bus(1'b0, 5'h14, 4'hF, 32'h0, 32'h00000000);
    lfsr_st = lfsr_next(lfsr_st);
    bus(1'b1, `HPRW_OFS_FUNC, 4'h3, {16'h0000, lfsr_st & 16'hFFF7}, 32'h0);
    bus(1'b0, `HPRW_OFS_FUNC, 4'hF, 32'h0, {16'h0000, lfsr_st & 16'hFFF7});
    bus(1'b1, `HPRW_OFS_FUNC, 4'h1, 32'h00003322, 32'h0);
    bus(1'b1, `HPRW_OFS_FUNC, 4'h2, 32'h00005500, 32'h0);
    bus(1'b0, `HPRW_OFS_FUNC, 4'hF, 32'h0, 32'h00002022);
    $display("test registers done");
    bus(1'b1, `HPRW_OFS_FUNC, 4'h1, 32'h00000002, 32'h0);
    pl_q.push_back({2'b01, 10'd32});
    bus(1'b1, `HPRW_OFS_WDOG, 4'h1, 32'h00000002, 32'h0);
    bus(1'b0, `HPRW_OFS_REPORT, 4'hF, 32'h0, 32'h00000202);
    wait_pulse(1'b0);
    bus(1'b0, `HPRW_OFS_WDOG, 4'hF, 32'h0, 32'h00000000);
    bus(1'b0, `HPRW_OFS_STATUS, 4'hF, 32'h0, 32'h00000001);
    // A running watchdog stopped by zero must never fire
    bus(1'b1, `HPRW_OFS_WDOG, 4'h1, 32'h00000003, 32'h0);
    bus(1'b1, `HPRW_OFS_WDOG, 4'h1, 32'h00000000, 32'h0);
    repeat (4 * 32 * T + 100) @(posedge sys_clk);
    $display("test watchdog done");
    bus(1'b1, `HPRW_OFS_FUNC, 4'h1, 32'h00000021, 32'h0);
    pl_q.push_back({2'b00, 10'd32});
    hold(1'b0, 200 * T, 1'b1);
    bus(1'b0, `HPRW_OFS_STATUS, 4'hF, 32'h0, 32'h00000007);
    bus(1'b1, `HPRW_OFS_FUNC, 4'h3, 32'h0000FFFF, 32'h0);
    // A boot store taken while locked would survive the restart
    bus(1'b1, `HPRW_OFS_BOOT, 4'hF, 32'h0, 32'h0);
    wait_pulse(1'b0);
    repeat (10) @(posedge sys_clk);
    bus(1'b0, `HPRW_OFS_FUNC, 4'hF, 32'h0, 32'h00002000);
    $display("test keypad reset done");
    bus(1'b1, `HPRW_OFS_FUNC, 4'h3, 32'h00000484, 32'h0);
    hold(1'b1, 64 * T, 1'b0);
    repeat (20 * T) @(posedge sys_clk);
    pl_q.push_back({2'b11, 10'd4});
    hold(1'b1, 200 * T, 1'b1);
    wait_pulse(1'b1);
    $display("test keypad power off done");
    bus(1'b1, `HPRW_OFS_FUNC, 4'h3, 32'h00000650, 32'h0);
    bus(1'b1, `HPRW_OFS_BOOT, 4'hF, 32'h0, 32'h0);
    bus(1'b0, `HPRW_OFS_BOOT, 4'hF, 32'h0, 32'h00000650);
    check("display_blank", display_blank, 1'b1);
    check("backlight_off", backlight_off, 1'b1);
    pl_q.push_back({2'b10, 10'd6});
    hold(1'b0, 40 * T, 1'b1);
    wait_pulse(1'b1);
    repeat (10) @(posedge sys_clk);
    check("display_blank", display_blank, 1'b0);
    bus(1'b0, `HPRW_OFS_FUNC, 4'hF, 32'h0, 32'h00000650);
    $display("test blank and power on done");
    // Cancel held past the pulse stretches it until release
    bus(1'b1, `HPRW_OFS_FUNC, 4'h3, 32'h00000484, 32'h0);
    pl_q.push_back({2'b11, 10'd24});
    hold(1'b1, 152 * T, 1'b0);
    wait_pulse(1'b1);
    $display("test power off stretch done");
    // Length 255 holds the line until the supply, here reset, goes away
    bus(1'b1, `HPRW_OFS_FUNC, 4'h3, 32'h0000FF40, 32'h0);
    pl_q.push_back({2'b10, 10'd64});
    hold(1'b0, 40 * T, 1'b1);
    repeat (64 * T) @(posedge sys_clk);
    check("pulse_held", pwr_pin_oe, 1'b1);
    arst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `HPRW_OFS_FUNC, 4'hF, 32'h0, 32'h00002000);
    check("notes_left", pl_q.size() + rd_q.size(), 0);
    $display("test held pulse and reset done");
    stop_test();
  end
endmodule : hprw_top_bench
